// ==== timer16_bus_if.sv ====
// Byte-wide register port between the controller and the timer.
// Assumes one clock shared by both ends.
`timescale 1ns/100ps
interface timer16_bus_if;
	logic       sel;
	logic       wr;
	logic [3:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic       irq;
	logic [3:0] irq_lines;

	modport device
	(
		input  sel,
		input  wr,
		input  addr,
		input  wdata,
		output rdata,
		output irq,
		output irq_lines
	);
	modport host
	(
		output sel,
		output wr,
		output addr,
		output wdata,
		input  rdata,
		input  irq,
		input  irq_lines
	);
endinterface

// ==== timer16_byte_access_props.sv ====
// Checker for the byte port that joins the controller and the timer.
// Assumes one clock, synchronous active-low reset, port seen directly.
`timescale 1ns/100ps
module timer16_byte_access_props
(
	input wire logic       sys_clk,
	input wire logic       rstn,
	input wire logic       sel,
	input wire logic       wr,
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	input wire logic [7:0] rdata,
	input wire logic       irq,
	input wire logic [3:0] irq_lines
);
	logic [7:0]  hold;
	logic        hold_ok;
	logic [15:0] cmp_a;
	logic [15:0] cmp_b;
	logic        cmp_ok;
	logic [15:0] cnt;
	logic        cnt_ok;
	logic        cs_off;
	logic [7:0]  mask;
	logic        rd;
	logic        wt;

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	// Read and write strobes of the byte port.
	assign rd = sel && !wr;
	assign wt = sel && wr;

	// Shadow of the holding byte; a low read of count or capture loads it unseen.
	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
		begin
			hold <= 8'h00;
			hold_ok <= 1'b1;
		end
		else if (wt && addr[0] && !addr[3])
		begin
			hold <= wdata;
			hold_ok <= 1'b1;
		end
		else if (rd && (addr == 4'h0 || addr == 4'h6))
			hold_ok <= 1'b0;
	end

	// Shadow of both compares, trusted only in modes that update them at once.
	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
		begin
			cmp_a <= 16'h0000;
			cmp_b <= 16'h0000;
			cmp_ok <= 1'b1;
		end
		else if (wt)
		begin
			if (addr == 4'h2)
				cmp_a <= {hold, wdata};
			if (addr == 4'h4)
				cmp_b <= {hold, wdata};
			if ((addr[3:1] == 3'h1 || addr[3:1] == 3'h2) && !addr[0] && !hold_ok)
				cmp_ok <= 1'b0;
			if ((addr == 4'h8 && wdata[1:0] != 2'h0) || (addr == 4'h9 && wdata[4]))
				cmp_ok <= 1'b0;
		end
	end

	// Shadow of the counter while no timer clock runs, and of the mask.
	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
		begin
			cnt <= 16'h0000;
			cnt_ok <= 1'b1;
			cs_off <= 1'b1;
			mask <= 8'h00;
		end
		else if (wt)
		begin
			if (addr == 4'h0)
			begin
				cnt <= {hold, wdata};
				cnt_ok <= hold_ok && cs_off;
			end
			if (addr == 4'h9)
			begin
				cs_off <= wdata[2:0] == 3'h0;
				if (wdata[2:0] != 3'h0)
					cnt_ok <= 1'b0;
			end
			if (addr == 4'hc)
				mask <= wdata;
		end
	end

	irq_or_a: assert property (
		irq == |irq_lines) else $error("irq differs from its lines");
	mask_gate_a: assert property (
		(irq_lines & ~{mask[5], mask[2], mask[1], mask[0]}) == 4'h0) else $error("masked line is active");
	hold_count_a: assert property (
		rd && addr == 4'h1 && hold_ok |-> rdata == hold) else $error("count high byte not from holding");
	hold_capt_a: assert property (
		rd && addr == 4'h7 && hold_ok |-> rdata == hold) else $error("capture high byte not from holding");
	cmp_a_lo_a: assert property (
		rd && addr == 4'h2 && cmp_ok |-> rdata == cmp_a[7:0]) else $error("compare A low byte wrong");
	cmp_a_hi_a: assert property (
		rd && addr == 4'h3 && cmp_ok |-> rdata == cmp_a[15:8]) else $error("compare A high byte wrong");
	cmp_b_read_a: assert property (
		rd && addr[3:1] == 3'h2 && cmp_ok |-> rdata == (addr[0] ? cmp_b[15:8] : cmp_b[7:0]))
		else $error("compare B byte wrong");
	count_still_a: assert property (
		rd && addr == 4'h0 && cnt_ok |-> rdata == cnt[7:0]) else $error("stopped counter moved");

	cover property (wt && addr == 4'h0);
	cover property (rd && addr == 4'h1 && !hold_ok);
	cover property (irq);
endmodule

// ==== timer16_byte_access_test.sv ====
// Testbench joining controller and timer through the byte port interface.
// Assumes the AXI4-Lite controller register map of the timer package.
`timescale 1ns/100ps
module timer16_byte_access_test;
	logic        sys_clk;
	logic        rstn;
	logic        cap_pin;
	logic        ext_pin;
	logic [7:0]  awaddr;
	logic        awvalid;
	logic        awready;
	logic [31:0] wdata;
	logic        wvalid;
	logic        wready;
	logic        bvalid;
	logic        bready;
	logic [7:0]  araddr;
	logic        arvalid;
	logic        arready;
	logic [31:0] rdata;
	logic        rvalid;
	logic        rready;
	logic        at_bottom;
	logic        at_max;
	logic [2:0]  outs;
	logic        seen_max = 1'b0;
	logic [31:0] r;
	logic [15:0] q;
	logic [15:0] v;
	int          n_mismatch = 0;
	int          total_checks = 0;
	int          cycles = 0;
	int          seed;

	timer16_bus_if timer16_bus_if_i();
	timer16_core timer16_core_i(.sys_clk(sys_clk), .rstn(rstn), .bus(timer16_bus_if_i),
		.capture_input_pin(cap_pin), .ext_count_pin(ext_pin), .compare_a_out(outs[0]), .compare_b_out(outs[1]),
		.at_bottom(at_bottom), .at_max(at_max), .at_top(outs[2]));
	timer16_ctrl timer16_ctrl_i(.sys_clk(sys_clk), .rstn(rstn), .bus(timer16_bus_if_i),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready));
	timer16_byte_access_props timer16_byte_access_props_i(.sys_clk(sys_clk), .rstn(rstn),
		.sel(timer16_bus_if_i.sel), .wr(timer16_bus_if_i.wr), .addr(timer16_bus_if_i.addr),
		.wdata(timer16_bus_if_i.wdata), .rdata(timer16_bus_if_i.rdata), .irq(timer16_bus_if_i.irq),
		.irq_lines(timer16_bus_if_i.irq_lines));

	// Clock of 10 ns period.
	initial
	begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// Cycle count for the hang limit, and a note of the counter reaching all ones.
	always @(posedge sys_clk)
	begin
		cycles <= cycles + 1;
		if (at_max === 1'b1)
			seen_max <= 1'b1;
		if (cycles == 20000)
		begin
			$display("FAIL %0t: timeout", $time);
			n_mismatch++;
			final_report();
		end
	end

	task chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("FAIL %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task axi_w(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge sys_clk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end
		while (!bvalid);
		bready <= 1'b0;
	endtask

	task axi_r(input logic [7:0] a, output logic [31:0] d);
		@(posedge sys_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge sys_clk);
			if (arready)
				arvalid <= 1'b0;
		end
		while (!rvalid);
		d = rdata;
		rready <= 1'b0;
	endtask

	// One timer access: command word, wait while busy, then fetch the result.
	task tcmd(input logic [5:0] c, input logic [15:0] d);
		axi_w(timer16_pkg::AXI_WDATA, {16'h0000, d});
		axi_w(timer16_pkg::AXI_CMD, {26'h0, c});
		do
			axi_r(timer16_pkg::AXI_STATUS, r);
		while (r[0] !== 1'b0);
		axi_r(timer16_pkg::AXI_RDATA, r);
		q = r[15:0];
	endtask

	task wr16(input logic [3:0] a, input logic [15:0] d);
		tcmd({2'b11, a}, d);
	endtask

	task wr8(input logic [3:0] a, input logic [15:0] d);
		tcmd({2'b10, a}, d);
	endtask

	task rd16(input logic [3:0] a, input logic [15:0] e);
		tcmd({2'b01, a}, 16'h0000);
		chk(q, e);
	endtask

	task rd8(input logic [3:0] a, input logic [15:0] e);
		tcmd({2'b00, a}, 16'h0000);
		chk({8'h00, q[7:0]}, e);
	endtask

	task final_report();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Main sequence of scenarios.
	initial
	begin
		seed = 4;
		rstn = 1'b0;
		cap_pin = 1'b0;
		ext_pin = 1'b0;
		awaddr = 8'h00;
		awvalid = 1'b0;
		wdata = 32'h0;
		wvalid = 1'b0;
		bready = 1'b0;
		araddr = 8'h00;
		arvalid = 1'b0;
		rready = 1'b0;
		repeat (4) @(posedge sys_clk);
		rstn <= 1'b1;
		rd8(4'h1, 16'h0000);
		rd8(4'hd, 16'h0001);
		wr8(4'hd, 16'h0000);
		for (int i = 0; i < 8; i++)
		begin
			v = (i == 0) ? 16'h0000 : (i == 1) ? 16'hffff : 16'($random(seed));
			wr16(4'h2, v);
			wr16(4'h4, ~v);
			wr16(4'h0, v ^ 16'h5a5a);
			rd16(4'h2, v);
			rd16(4'h4, ~v);
			rd16(4'h0, v ^ 16'h5a5a);
		end
		wr8(4'h1, 16'h00c3);
		rd8(4'h3, {8'h00, v[15:8]});
		rd8(4'h7, 16'h00c3);
		rd8(4'h1, 16'h00c3);
		v = v ^ 16'h5a5a;
		rd8(4'h0, {8'h00, v[7:0]});
		rd8(4'h1, {8'h00, v[15:8]});
		$display("test byte access done");
		wr8(4'hc, 16'h0027);
		wr16(4'h2, 16'h0010);
		wr16(4'h4, 16'h0020);
		wr16(4'h0, 16'hfff0);
		wr8(4'h9, 16'h0001);
		repeat (80) @(posedge sys_clk);
		wr8(4'h9, 16'h0000);
		rd8(4'hb, 16'h0007);
		axi_r(timer16_pkg::AXI_IRQ, r);
		chk(r[15:0], 16'h0017);
		chk({15'h0, seen_max}, 16'h0001);
		chk({13'h0, outs}, 16'h0003);
		wr8(4'hb, 16'h0007);
		rd8(4'hb, 16'h0000);
		$display("test flags done");
		wr16(4'h0, 16'h0000);
		chk({15'h0, at_bottom}, 16'h0001);
		wr8(4'h9, 16'h0007);
		repeat (5)
		begin
			repeat (4) @(posedge sys_clk);
			ext_pin <= 1'b1;
			repeat (4) @(posedge sys_clk);
			ext_pin <= 1'b0;
		end
		wr8(4'h9, 16'h0000);
		rd16(4'h0, 16'h0005);
		$display("test external clock done");
		wr16(4'h0, 16'h1234);
		wr8(4'h9, 16'h0040);
		rd8(4'h9, 16'h0040);
		cap_pin <= 1'b1;
		repeat (6) @(posedge sys_clk);
		cap_pin <= 1'b0;
		rd16(4'h6, 16'h1234);
		wr16(4'h0, 16'h4321);
		wr8(4'h9, 16'h00c0);
		cap_pin <= 1'b1;
		@(posedge sys_clk);
		cap_pin <= 1'b0;
		repeat (8) @(posedge sys_clk);
		rd16(4'h6, 16'h1234);
		cap_pin <= 1'b1;
		repeat (10) @(posedge sys_clk);
		rd16(4'h6, 16'h4321);
		$display("test capture done");
		wr16(4'h2, 16'h0005);
		wr16(4'h0, 16'h0000);
		wr8(4'h9, 16'h0009);
		repeat (37) @(posedge sys_clk);
		wr8(4'h9, 16'h0008);
		tcmd(6'h10, 16'h0000);
		chk({15'h0, q <= 16'h0005}, 16'h0001);
		chk({13'h0, outs}, {13'h0, q == 16'h0005, 2'h3});
		$display("test compare top done");
		final_report();
	end
endmodule

// ==== timer16_core.sv ====
// Behaviour
// - Wide registers move as two byte accesses.
// - One shared high-byte holding register.
// - Low-byte write loads holding plus low.
// - Count and capture low-byte reads stage high byte in holding.
// - Compare reads bypass the holding register.
// - Write high first, read low first.
// - Caller keeps two-byte transfers uninterrupted.
// - Bottom signalled when counter becomes zero.
// - Max signalled when counter becomes all ones.
// - Top is fixed, compare A or capture.
// - Compare A top is double buffered, except in CTC mode.
// - Compares checked on each timer tick, matches set flags.
// - Counter advances only on selected clock.
// - Capture edge stores counter, optional filter.
// - Four flags visible, each masked separately.
// - Power-off bit must clear before operation.
// - Control bytes accessed directly, no holding.
// - Counter write beats clear or count.
// Timer end: 16-bit counter, compares, capture and the byte register port.
// Assumes the register port and pins are synchronous to sys_clk.
`timescale 1ns/100ps
module timer16_core
(
	input  wire logic   sys_clk,
	input  wire logic   rstn,
	timer16_bus_if.device bus,
	input  wire logic   capture_input_pin,
	input  wire logic   ext_count_pin,
	output logic        compare_a_out,
	output logic        compare_b_out,
	output logic        at_bottom,
	output logic        at_max,
	output logic        at_top
);
	logic [7:0]  hold_byte;
	logic [15:0] timer16_count;
	logic [15:0] compare_a_value;
	logic [15:0] compare_b_value;
	logic [15:0] compare_a_live;
	logic [15:0] compare_b_live;
	logic [15:0] capture_value;
	logic [7:0]  timer16_control_a;
	logic [7:0]  timer16_control_b;
	logic [7:0]  timer16_control_c;
	logic [7:0]  timer16_flag_reg;
	logic [7:0]  timer16_irq_mask;
	logic [7:0]  power_reduction_0;
	logic [9:0]  prescale;
	logic        ext_prev;
	logic        cap_prev;
	logic        cap_stable;
	logic [2:0]  cap_run;
	logic        tick;
	logic        running;
	logic [3:0]  mode;
	logic [15:0] top;
	logic        top_from_a;
	logic        wr_lo;
	logic        rd_lo;
	logic        count_wr;
	logic        cap_event;
	logic        cap_src;
	logic        match_a;
	logic        match_b;
	logic        overflow;
	logic [15:0] next_count;

	assign mode    = {timer16_control_b[timer16_pkg::CB_WGMH_LSB +: 2],
		timer16_control_a[timer16_pkg::CA_WGML_LSB +: 2]};
	assign running = ~power_reduction_0[timer16_pkg::POWER_BIT];
	assign wr_lo   = bus.sel & bus.wr & ~bus.addr[0] & ~bus.addr[3];
	assign rd_lo   = bus.sel & ~bus.wr & ~bus.addr[0] & ~bus.addr[3];
	assign count_wr = wr_lo & (bus.addr == timer16_pkg::ADDR_COUNT_LO);

	// Top source: fixed, compare A or capture, chosen by mode.
	// top selection
	always_comb
	begin
		top_from_a = 1'b0;
		unique case (mode)
			timer16_pkg::WGM_PWM8, timer16_pkg::WGM_FAST8:   top = timer16_pkg::TOP_8BIT;
			timer16_pkg::WGM_PWM9, timer16_pkg::WGM_FAST9:   top = timer16_pkg::TOP_9BIT;
			timer16_pkg::WGM_PWM10, timer16_pkg::WGM_FAST10: top = timer16_pkg::TOP_10BIT;
			timer16_pkg::WGM_PFC_I, timer16_pkg::WGM_PC_I,
			timer16_pkg::WGM_CTC_I, timer16_pkg::WGM_FAST_I: top = capture_value;
			timer16_pkg::WGM_CTC_A, timer16_pkg::WGM_PFC_A,
			timer16_pkg::WGM_PC_A, timer16_pkg::WGM_FAST_A:
			begin
				top        = compare_a_live;
				top_from_a = 1'b1;
			end
			default:                                         top = timer16_pkg::MAX;
		endcase
	end

	// Prescaler and clock select produce a one-cycle tick.
	// timer clock select
	always_comb
	begin
		unique case (timer16_control_b[timer16_pkg::CB_CS_LSB +: 3])
			timer16_pkg::CS_OFF:      tick = 1'b0;
			timer16_pkg::CS_DIV1:     tick = running;
			timer16_pkg::CS_DIV8:     tick = running & (prescale[2:0] == 3'h7);
			timer16_pkg::CS_DIV64:    tick = running & (prescale[5:0] == 6'h3f);
			timer16_pkg::CS_DIV256:   tick = running & (prescale[7:0] == 8'hff);
			timer16_pkg::CS_DIV1024:  tick = running & (prescale == 10'h3ff);
			timer16_pkg::CS_EXT_FALL: tick = running & ext_prev & ~ext_count_pin;
			default:                  tick = running & ~ext_prev & ext_count_pin;
		endcase
	end

	// Free-running prescaler and pin history.
	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
		begin
			prescale <= 10'h000;
			ext_prev <= 1'b0;
		end
		else
		begin
			prescale <= running ? prescale + 10'h001 : 10'h000;
			ext_prev <= ext_count_pin;
		end
	end

	// Counter: a CPU write wins over counting and wrapping.
	assign overflow = tick & (timer16_count == top);
	always_comb
	begin
		next_count = timer16_count;
		if (count_wr)
			next_count = {hold_byte, bus.wdata};
		else if (overflow)
			next_count = timer16_pkg::BOTTOM;
		else if (tick)
			next_count = timer16_count + 16'h0001;
	end
	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
			timer16_count <= timer16_pkg::WORD_RESET;
		else
			timer16_count <= next_count;
	end

	assign at_bottom = (timer16_count == timer16_pkg::BOTTOM);
	assign at_max    = (timer16_count == timer16_pkg::MAX);
	assign at_top    = (timer16_count == top);

	// Compare buffers move to the live copies at top, or at once in mode 0 and the CTC modes.
	// double buffered top
	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
		begin
			compare_a_live <= timer16_pkg::WORD_RESET;
			compare_b_live <= timer16_pkg::WORD_RESET;
		end
		else if (overflow || mode == 4'h0 || mode == timer16_pkg::WGM_CTC_A || mode == timer16_pkg::WGM_CTC_I)
		begin
			compare_a_live <= compare_a_value;
			compare_b_live <= compare_b_value;
		end
	end

	assign match_a = tick & (timer16_count == compare_a_live);
	assign match_b = tick & (timer16_count == compare_b_live);

	// Waveform outputs toggle on match; channel A is silent when it sets the top.
	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
		begin
			compare_a_out <= 1'b0;
			compare_b_out <= 1'b0;
		end
		else
		begin
			if (match_a && !top_from_a)
				compare_a_out <= ~compare_a_out;
			if (match_b)
				compare_b_out <= ~compare_b_out;
		end
	end

	// Capture pin: optional filter needs four equal samples, then edge detect.
	// capture filter
	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
		begin
			cap_run    <= 3'h0;
			cap_stable <= 1'b0;
			cap_prev   <= 1'b0;
		end
		else
		begin
			if (capture_input_pin == cap_stable)
				cap_run <= 3'h0;
			else if (cap_run == timer16_pkg::FILTER_LEN - 3'h1)
			begin
				cap_run    <= 3'h0;
				cap_stable <= capture_input_pin;
			end
			else
				cap_run <= cap_run + 3'h1;
			cap_prev <= cap_src;
		end
	end
	assign cap_src   = timer16_control_b[timer16_pkg::CB_FILTER] ? cap_stable : capture_input_pin;
	assign cap_event = running & (cap_src != cap_prev) & (cap_src == timer16_control_b[timer16_pkg::CB_EDGE]);

	// Wide registers: low-byte writes merge the held high byte.
	// atomic low write
	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
		begin
			compare_a_value <= timer16_pkg::WORD_RESET;
			compare_b_value <= timer16_pkg::WORD_RESET;
			capture_value   <= timer16_pkg::WORD_RESET;
		end
		else
		begin
			if (wr_lo && bus.addr == timer16_pkg::ADDR_CMP_A_LO)
				compare_a_value <= {hold_byte, bus.wdata};
			if (wr_lo && bus.addr == timer16_pkg::ADDR_CMP_B_LO)
				compare_b_value <= {hold_byte, bus.wdata};
			if (wr_lo && bus.addr == timer16_pkg::ADDR_CAPT_LO)
				capture_value <= {hold_byte, bus.wdata};
			else if (cap_event)
				capture_value <= timer16_count;
		end
	end

	// Shared holding byte: high writes load it, count and capture low reads stage into it.
	// single holding byte
	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
			hold_byte <= timer16_pkg::BYTE_RESET;
		else if (bus.sel && bus.wr && bus.addr[0] && !bus.addr[3])
			hold_byte <= bus.wdata;
		else if (rd_lo && bus.addr == timer16_pkg::ADDR_COUNT_LO)
			hold_byte <= timer16_count[15:8];
		else if (rd_lo && bus.addr == timer16_pkg::ADDR_CAPT_LO)
			hold_byte <= capture_value[15:8];
	end

	// Byte control registers and flags; a hardware set beats a one-to-clear.
	// direct byte access
	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
		begin
			timer16_control_a <= timer16_pkg::BYTE_RESET;
			timer16_control_b <= timer16_pkg::BYTE_RESET;
			timer16_control_c <= timer16_pkg::BYTE_RESET;
			timer16_irq_mask  <= timer16_pkg::BYTE_RESET;
			power_reduction_0 <= timer16_pkg::POWER_RESET;
			timer16_flag_reg  <= timer16_pkg::BYTE_RESET;
		end
		else
		begin
			if (bus.sel && bus.wr)
			begin
				unique case (bus.addr)
					timer16_pkg::ADDR_CTRL_A: timer16_control_a <= bus.wdata;
					timer16_pkg::ADDR_CTRL_B: timer16_control_b <= bus.wdata;
					timer16_pkg::ADDR_CTRL_C: timer16_control_c <= bus.wdata;
					timer16_pkg::ADDR_MASK:   timer16_irq_mask  <= bus.wdata;
					timer16_pkg::ADDR_POWER:  power_reduction_0 <= bus.wdata;
					default:                  ;
				endcase
			end
			timer16_flag_reg <= (timer16_flag_reg
				& ~((bus.sel && bus.wr && bus.addr == timer16_pkg::ADDR_FLAGS) ? bus.wdata : 8'h00))
				| ({7'h00, overflow} << timer16_pkg::FLAG_OVF)
				| ({7'h00, match_a} << timer16_pkg::FLAG_CMPA)
				| ({7'h00, match_b} << timer16_pkg::FLAG_CMPB)
				| ({7'h00, cap_event} << timer16_pkg::FLAG_CAPT);
		end
	end

	// Read data; compare reads return the high byte directly.
	// compare read bypass
	always_comb
	begin
		unique case (bus.addr)
			timer16_pkg::ADDR_COUNT_LO: bus.rdata = timer16_count[7:0];
			timer16_pkg::ADDR_CMP_A_LO: bus.rdata = compare_a_value[7:0];
			timer16_pkg::ADDR_CMP_A_HI: bus.rdata = compare_a_value[15:8];
			timer16_pkg::ADDR_CMP_B_LO: bus.rdata = compare_b_value[7:0];
			timer16_pkg::ADDR_CMP_B_HI: bus.rdata = compare_b_value[15:8];
			timer16_pkg::ADDR_CAPT_LO:  bus.rdata = capture_value[7:0];
			timer16_pkg::ADDR_COUNT_HI, timer16_pkg::ADDR_CAPT_HI: bus.rdata = hold_byte;
			timer16_pkg::ADDR_CTRL_A:   bus.rdata = timer16_control_a;
			timer16_pkg::ADDR_CTRL_B:   bus.rdata = timer16_control_b;
			timer16_pkg::ADDR_CTRL_C:   bus.rdata = timer16_control_c;
			timer16_pkg::ADDR_FLAGS:    bus.rdata = timer16_flag_reg;
			timer16_pkg::ADDR_MASK:     bus.rdata = timer16_irq_mask;
			timer16_pkg::ADDR_POWER:    bus.rdata = power_reduction_0;
			default:                    bus.rdata = 8'h00;
		endcase
	end

	assign bus.irq_lines = {timer16_flag_reg[timer16_pkg::FLAG_CAPT], timer16_flag_reg[2:0]}
		& {timer16_irq_mask[timer16_pkg::FLAG_CAPT], timer16_irq_mask[2:0]};
	assign bus.irq = |bus.irq_lines;
endmodule

// ==== timer16_ctrl.sv ====
// Controller end: AXI4-Lite slave turning word commands into byte accesses.
// Assumes the timer answers reads combinationally in the same cycle.
`timescale 1ns/100ps
module timer16_ctrl
(
	input  wire logic        sys_clk,
	input  wire logic        rstn,
	timer16_bus_if.host      bus,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	typedef enum logic [1:0] {IDLE = 2'b00, FIRST = 2'b01, SECOND = 2'b10} seq_t;
	seq_t        seq;
	logic [5:0]  cmd;
	logic [15:0] wword;
	logic [15:0] rword;
	logic        busy;
	logic        aw_hold;
	logic        w_hold;
	logic [7:0]  aw_addr;
	logic [31:0] w_data;
	logic        do_write;

	assign s_axi_awready = ~aw_hold & ~s_axi_bvalid;
	assign s_axi_wready  = ~w_hold & ~s_axi_bvalid;
	assign s_axi_arready = ~s_axi_rvalid;
	assign do_write      = aw_hold & w_hold;
	assign s_axi_bresp   = 2'b00;
	assign s_axi_rresp   = 2'b00;

	// Write channel: take address and data in any order, answer once both are in.
	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
		begin
			aw_hold      <= 1'b0;
			w_hold       <= 1'b0;
			aw_addr      <= 8'h00;
			w_data       <= 32'h00000000;
			s_axi_bvalid <= 1'b0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_hold <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_hold <= 1'b1;
				w_data <= s_axi_wdata;
			end
			if (do_write)
			begin
				aw_hold      <= 1'b0;
				w_hold       <= 1'b0;
				s_axi_bvalid <= 1'b1;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// Register file writes; a command starts a byte sequence when idle.
	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
		begin
			cmd   <= 6'h00;
			wword <= 16'h0000;
		end
		else if (do_write && s_axi_wstrb[0])
		begin
			if (aw_addr == timer16_pkg::AXI_CMD && !busy)
				cmd <= w_data[5:0];
			if (aw_addr == timer16_pkg::AXI_WDATA)
				wword <= w_data[15:0];
		end
	end

	// Byte sequencer: writes go high then low, reads go low then high.
	// byte order
	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
		begin
			seq   <= IDLE;
			busy  <= 1'b0;
			rword <= 16'h0000;
		end
		else
		begin
			unique case (seq)
				IDLE:
					if (do_write && aw_addr == timer16_pkg::AXI_CMD && s_axi_wstrb[0] && !busy)
					begin
						seq  <= FIRST;
						busy <= 1'b1;
					end
				FIRST:
				begin
					if (!cmd[timer16_pkg::CMD_WRITE])
						rword[7:0] <= bus.rdata;
					seq <= cmd[timer16_pkg::CMD_WIDE] ? SECOND : IDLE;
					busy <= cmd[timer16_pkg::CMD_WIDE];
				end
				SECOND:
				begin
					if (!cmd[timer16_pkg::CMD_WRITE])
						rword[15:8] <= bus.rdata;
					seq  <= IDLE;
					busy <= 1'b0;
				end
				default:
					seq <= IDLE;
			endcase
		end
	end

	// Byte port drive; a sequence is never split, so the holding byte stays ours.
	// uninterrupted pair
	always_comb
	begin
		bus.sel   = (seq != IDLE);
		bus.wr    = cmd[timer16_pkg::CMD_WRITE];
		bus.addr  = cmd[3:0];
		bus.wdata = wword[7:0];
		if (cmd[timer16_pkg::CMD_WIDE])
		begin
			if ((seq == FIRST) == cmd[timer16_pkg::CMD_WRITE])
			begin
				bus.addr  = {cmd[3:1], 1'b1};
				bus.wdata = wword[15:8];
			end
			else
				bus.addr = {cmd[3:1], 1'b0};
		end
	end

	// Read channel with one cycle latency.
	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			unique case (s_axi_araddr)
				timer16_pkg::AXI_CMD:    s_axi_rdata <= {26'h0, cmd};
				timer16_pkg::AXI_WDATA:  s_axi_rdata <= {16'h0, wword};
				timer16_pkg::AXI_RDATA:  s_axi_rdata <= {16'h0, rword};
				timer16_pkg::AXI_STATUS: s_axi_rdata <= {31'h0, busy};
				timer16_pkg::AXI_IRQ:    s_axi_rdata <= {27'h0, bus.irq, bus.irq_lines};
				default:                 s_axi_rdata <= 32'h00000000;
			endcase
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end
endmodule

// ==== timer16_pkg.sv ====
// Package for the 16-bit timer with byte-wide register access.
// Assumes an 8-bit register port between a controller and the timer.
package timer16_pkg;
	// Byte addresses of the timer registers on the 8-bit port.
	localparam logic [3:0] ADDR_COUNT_LO   = 4'h0;
	localparam logic [3:0] ADDR_COUNT_HI   = 4'h1;
	localparam logic [3:0] ADDR_CMP_A_LO   = 4'h2;
	localparam logic [3:0] ADDR_CMP_A_HI   = 4'h3;
	localparam logic [3:0] ADDR_CMP_B_LO   = 4'h4;
	localparam logic [3:0] ADDR_CMP_B_HI   = 4'h5;
	localparam logic [3:0] ADDR_CAPT_LO    = 4'h6;
	localparam logic [3:0] ADDR_CAPT_HI    = 4'h7;
	localparam logic [3:0] ADDR_CTRL_A     = 4'h8;
	localparam logic [3:0] ADDR_CTRL_B     = 4'h9;
	localparam logic [3:0] ADDR_CTRL_C     = 4'ha;
	localparam logic [3:0] ADDR_FLAGS      = 4'hb;
	localparam logic [3:0] ADDR_MASK       = 4'hc;
	localparam logic [3:0] ADDR_POWER      = 4'hd;
	// Flag and mask bit positions.
	localparam int FLAG_OVF  = 0;
	localparam int FLAG_CMPA = 1;
	localparam int FLAG_CMPB = 2;
	localparam int FLAG_CAPT = 5;
	// Control B fields: clock select, mode bits 3:2, edge, filter.
	localparam int CB_CS_LSB   = 0;
	localparam int CB_WGMH_LSB = 3;
	localparam int CB_EDGE     = 6;
	localparam int CB_FILTER   = 7;
	localparam int CA_WGML_LSB = 0;
	localparam int POWER_BIT   = 0;
	// Clock selections.
	localparam logic [2:0] CS_OFF     = 3'h0;
	localparam logic [2:0] CS_DIV1    = 3'h1;
	localparam logic [2:0] CS_DIV8    = 3'h2;
	localparam logic [2:0] CS_DIV64   = 3'h3;
	localparam logic [2:0] CS_DIV256  = 3'h4;
	localparam logic [2:0] CS_DIV1024 = 3'h5;
	localparam logic [2:0] CS_EXT_FALL = 3'h6;
	// Fixed top values and counter limits.
	localparam logic [15:0] TOP_8BIT  = 16'h00ff;
	localparam logic [15:0] TOP_9BIT  = 16'h01ff;
	localparam logic [15:0] TOP_10BIT = 16'h03ff;
	localparam logic [15:0] BOTTOM    = 16'h0000;
	localparam logic [15:0] MAX       = 16'hffff;
	// Mode codes that choose the top source.
	localparam logic [3:0] WGM_PWM8   = 4'h1;
	localparam logic [3:0] WGM_PWM9   = 4'h2;
	localparam logic [3:0] WGM_PWM10  = 4'h3;
	localparam logic [3:0] WGM_CTC_A  = 4'h4;
	localparam logic [3:0] WGM_FAST8  = 4'h5;
	localparam logic [3:0] WGM_FAST9  = 4'h6;
	localparam logic [3:0] WGM_FAST10 = 4'h7;
	localparam logic [3:0] WGM_PFC_I  = 4'h8;
	localparam logic [3:0] WGM_PFC_A  = 4'h9;
	localparam logic [3:0] WGM_PC_I   = 4'ha;
	localparam logic [3:0] WGM_PC_A   = 4'hb;
	localparam logic [3:0] WGM_CTC_I  = 4'hc;
	localparam logic [3:0] WGM_FAST_I = 4'he;
	localparam logic [3:0] WGM_FAST_A = 4'hf;
	// Filter needs this many equal samples.
	localparam logic [2:0] FILTER_LEN = 3'h4;
	// Resets.
	localparam logic [7:0]  BYTE_RESET = 8'h00;
	localparam logic [7:0]  POWER_RESET = 8'h01;
	localparam logic [15:0] WORD_RESET = 16'h0000;
	// Controller register offsets on AXI4-Lite.
	localparam logic [7:0] AXI_CMD    = 8'h00;
	localparam logic [7:0] AXI_WDATA  = 8'h04;
	localparam logic [7:0] AXI_RDATA  = 8'h08;
	localparam logic [7:0] AXI_STATUS = 8'h0c;
	localparam logic [7:0] AXI_IRQ    = 8'h10;
	// Command word fields.
	localparam int CMD_ADDR_LSB = 0;
	localparam int CMD_WIDE     = 4;
	localparam int CMD_WRITE    = 5;
endpackage
